// file: include/dms_pkg.sv
// Shared constants and types for the debug-mode and security register block
package dms_pkg;
    // Address groups
    localparam logic [15:0] DP_LO          = 16'h0000;
    localparam logic [15:0] DP_HI          = 16'h005f;
    localparam logic [15:0] HP_LO          = 16'h1800;
    localparam logic [15:0] HP_HI          = 16'h184f;
    localparam logic [15:0] NV_LO          = 16'hffb0;
    localparam logic [15:0] NV_HI          = 16'hffbf;
    // High-page offsets
    localparam logic [15:0] OFS_RST_SRC    = 16'h1800;
    localparam logic [15:0] OFS_FORCE_RST  = 16'h1801;
    localparam logic [15:0] OFS_OPT_ONE    = 16'h1802;
    localparam logic [15:0] OFS_OPT_TWO    = 16'h1803;
    localparam logic [15:0] OFS_ID_HIGH    = 16'h1806;
    localparam logic [15:0] OFS_ID_LOW     = 16'h1807;
    localparam logic [15:0] OFS_WAKEUP     = 16'h1808;
    localparam logic [15:0] OFS_PMC_ONE    = 16'h1809;
    localparam logic [15:0] OFS_PMC_TWO    = 16'h180a;
    localparam logic [15:0] OFS_PMC_THREE  = 16'h180c;
    localparam logic [15:0] OFS_CMPA_HIGH  = 16'h1810;
    localparam logic [15:0] OFS_CMPA_LOW   = 16'h1811;
    localparam logic [15:0] OFS_CMPB_HIGH  = 16'h1812;
    localparam logic [15:0] OFS_CMPB_LOW   = 16'h1813;
    localparam logic [15:0] OFS_TRACE_HIGH = 16'h1814;
    localparam logic [15:0] OFS_TRACE_LOW  = 16'h1815;
    localparam logic [15:0] OFS_WORK_OPT   = 16'h1816;
    localparam logic [15:0] OFS_KEY_ENTRY  = 16'h1818;
    localparam logic [15:0] OFS_SEC_STAT   = 16'h1819;
    // Nonvolatile offsets
    localparam logic [15:0] OFS_FINE_TRIM  = 16'hffae;
    localparam logic [15:0] OFS_OSC_TRIM   = 16'hffaf;
    localparam logic [15:0] OFS_KEY_LO     = 16'hffb0;
    localparam logic [15:0] OFS_KEY_HI     = 16'hffb7;
    localparam logic [15:0] OFS_PROT       = 16'hffbd;
    localparam logic [15:0] OFS_NV_OPT     = 16'hffbf;
    // Fields
    localparam int          KEY_ENABLE_BIT_BIT      = 7;
    localparam int          FORCE_RST_BIT  = 0;
    localparam logic [1:0]  SEC_UNSECURED  = 2'b10;
    localparam int          KEY_BYTES      = 8;
    // Reset values
    localparam logic [7:0]  OPT_ONE_RST    = 8'h00;
    localparam logic [7:0]  OPT_TWO_RST    = 8'h00;
    localparam logic [7:0]  PMC_RST        = 8'h00;

    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_WAIT = 2'b01,
        MODE_BGND = 2'b10
    } dms_mode_t;

    typedef enum logic [2:0] {
        CMD_MEM        = 3'b000,
        CMD_MEM_STAT   = 3'b001,
        CMD_BDC_REG    = 3'b010,
        CMD_BACKGROUND = 3'b011,
        CMD_CPU_REG    = 3'b100,
        CMD_TRACE      = 3'b101,
        CMD_GO         = 3'b110
    } dms_cmd_t;
endpackage : dms_pkg

// file: include/dms_dbg_if.sv
// Debug command gating signals between the top and the command filter
`timescale 1ns/1ns
`default_nettype none
interface dms_dbg_if;
    logic              valid;
    dms_pkg::dms_cmd_t cls;
    dms_pkg::dms_mode_t mode;
    logic              exec;
    logic              reject;
    logic              lp_err;
    modport gate (input valid, cls, mode, output exec, reject, lp_err);
    modport top  (output valid, cls, mode, input exec, reject, lp_err);
endinterface : dms_dbg_if
`default_nettype wire

// file: src/dms_key_mem.sv
// Small comparison-key memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module dms_key_mem #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock
    input  wire logic                 clk_sys,
    // Write port
    input  wire logic                 we,
    input  wire logic [$clog2(D)-1:0] waddr,
    input  wire logic [W-1:0]         wdata,
    // Read port
    input  wire logic [$clog2(D)-1:0] raddr,
    output logic      [W-1:0]         rdata
);
    logic [W-1:0] mem [D];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        rdata <= mem[raddr];
    end
endmodule : dms_key_mem
`default_nettype wire

// file: src/dms_cmd_gate.sv
// Debug command filter by operating mode
`timescale 1ns/1ns
`default_nettype none
module dms_cmd_gate (
    // Clock and reset, for checks only
    input  wire logic clk_sys,
    input  wire logic rst,
    // Command path
    dms_dbg_if.gate   dbg
);
    logic nonintr;
    logic wait_ok;

    // Memory, status-memory, controller register and background request
    assign nonintr = dbg.cls inside {dms_pkg::CMD_MEM, dms_pkg::CMD_MEM_STAT,
                                     dms_pkg::CMD_BDC_REG, dms_pkg::CMD_BACKGROUND};
    assign wait_ok = dbg.cls inside {dms_pkg::CMD_BACKGROUND, dms_pkg::CMD_MEM_STAT};

    always_comb begin
        dbg.exec   = 1'b0;
        dbg.reject = 1'b0;
        dbg.lp_err = 1'b0;
        if (dbg.valid) begin
            unique case (dbg.mode)
                dms_pkg::MODE_RUN: begin
                    dbg.exec   = nonintr;
                    dbg.reject = !nonintr;
                end
                dms_pkg::MODE_WAIT: begin
                    // Status query answers without touching memory
                    dbg.exec   = dbg.cls == dms_pkg::CMD_BACKGROUND;
                    dbg.lp_err = dbg.cls == dms_pkg::CMD_MEM_STAT;
                    dbg.reject = !wait_ok;
                end
                dms_pkg::MODE_BGND: begin
                    dbg.exec   = dbg.cls != 3'h7;
                    dbg.reject = dbg.cls == 3'h7;
                end
                default: begin
                    dbg.reject = 1'b1;
                end
            endcase
        end
    end

    a_wait_gate_cmds: assert property (@(posedge clk_sys) disable iff (rst)
        dbg.valid && dbg.mode == dms_pkg::MODE_WAIT && !wait_ok |-> dbg.reject && !dbg.exec)
        else $error("command not refused in wait");
    a_stat_no_access: assert property (@(posedge clk_sys) disable iff (rst)
        dbg.valid && dbg.mode == dms_pkg::MODE_WAIT && dbg.cls == dms_pkg::CMD_MEM_STAT
        |-> dbg.lp_err && !dbg.exec)
        else $error("status access in wait touched memory");
    a_run_nonintr: assert property (@(posedge clk_sys) disable iff (rst)
        dbg.valid && dbg.mode == dms_pkg::MODE_RUN |-> dbg.exec == nonintr)
        else $error("run mode command gating wrong");
endmodule : dms_cmd_gate
`default_nettype wire

// file: src/dms_sysregs.sv
// System register bank with debug mode gating, wait mode and memory security
// Behaviour
// - Active background mode suspends user instructions; only debug commands proceed.
// - Non-intrusive debug commands run in run mode and active background mode.
// - Non-intrusive: memory, memory with status, controller registers, background request.
// - CPU register, trace and resume commands execute only in active background.
// - Wait instruction stops the CPU clock.
// - Entering wait clears the interrupt mask bit.
// - Interrupt in wait resumes processing with the stacking sequence.
// - In wait only background request and status memory commands are accepted.
// - Status memory command in wait skips access and reports low-power error.
// - Background request in wait wakes into active background mode.
// - Decode the high page range and fixed nonvolatile offsets; direct page addresses are not decoded and read as zero.
// - High-page registers start at 0x1800, outside direct addressing.
// - With key enable set, an 8-byte key can disengage security.
// - Key entry only from secure code, never from debug commands.
// - With key enable clear, only mass erase plus blank check unsecures.
// - Security bits 1:0 = 10 mean unsecured.
// - All other security bit values, erased included, engage security.
// - During reset the option byte is copied into the working option register.
// - When secure, unsecured or debug access to secure memory is blocked.
`timescale 1ns/1ns
`default_nettype none
module dms_sysregs #(
    parameter logic [7:0] ID_HIGH = 8'h05, // Arbitrary identity value
    parameter logic [7:0] ID_LOW  = 8'ha3  // Arbitrary identity value
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_from_dbg,
    input  wire logic        reg_src_secure,
    output logic      [7:0]  reg_rdata,
    // Nonvolatile load and reset capture
    input  wire logic [7:0]  nv_opt_in,
    input  wire logic [7:0]  nv_prot_in,
    input  wire logic [7:0]  nv_fine_trim,
    input  wire logic [7:0]  nv_osc_trim,
    input  wire logic        nv_key_we,
    input  wire logic [2:0]  nv_key_idx,
    input  wire logic [7:0]  nv_key_data,
    input  wire logic [7:0]  rst_cause,
    input  wire logic [15:0] trace_word,
    // Flash erase results
    input  wire logic        mass_erase_done,
    input  wire logic        blank_ok,
    // CPU side
    input  wire logic        wait_instr,
    input  wire logic        irq_req,
    output logic             cpu_run,
    output logic             cpu_clk_en,
    output logic             ccr_i_clr,
    output logic             stack_start,
    output logic             trace_step,
    output logic             force_rst,
    // Debug commands
    input  wire logic        dbg_valid,
    input  wire logic [2:0]  dbg_cls,
    output logic             dbg_exec,
    output logic             dbg_reject,
    output logic             dbg_lp_err,
    // Secure memory access check
    input  wire logic        mem_req,
    input  wire logic        mem_tgt_secure,
    input  wire logic        mem_src_secure,
    input  wire logic        mem_src_dbg,
    output logic             mem_allow,
    // Security state
    output logic             secure,
    output logic             redirect_off
);
    dms_pkg::dms_mode_t mode_ff;
    dms_pkg::dms_mode_t nxt_mode;
    logic [7:0]  working_option_register_ff;
    logic [7:0]  prot_ff;
    logic [7:0]  srs_ff;
    logic [7:0]  opt1_ff;
    logic [7:0]  opt2_ff;
    logic [7:0]  wake_ff;
    logic [7:0]  pmc1_ff;
    logic [7:0]  pmc2_ff;
    logic [7:0]  pmc3_ff;
    logic [15:0] cmpa_ff;
    logic [15:0] cmpb_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        ccr_i_clr_ff;
    logic        stack_ff;
    logic        trace_ff;
    logic        force_ff;
    logic [2:0]  key_idx_ff;
    logic        key_pend_ff;
    logic        key_last_ff;
    logic        key_miss_ff;
    logic [7:0]  key_byte_ff;
    logic        key_unsec_ff;
    logic        erase_seen_ff;
    logic        erase_unsec_ff;
    logic [7:0]  key_rdata;
    logic        key_wr;
    logic        key_bad;
    logic        bg_req;

    dms_dbg_if dbg ();
    assign dbg.valid  = dbg_valid;
    assign dbg.cls    = dms_pkg::dms_cmd_t'(dbg_cls);
    assign dbg.mode   = mode_ff;
    assign dbg_exec   = dbg.exec;
    assign dbg_reject = dbg.reject;
    assign dbg_lp_err = dbg.lp_err;
    assign bg_req     = dbg.exec && dbg.cls == dms_pkg::CMD_BACKGROUND;

    dms_cmd_gate u_gate (
        .clk_sys (clk_sys),
        .rst     (rst),
        .dbg     (dbg.gate)
    );

    dms_key_mem #(.W(8), .D(dms_pkg::KEY_BYTES)) u_key (
        .clk_sys (clk_sys),
        .we      (nv_key_we),
        .waddr   (nv_key_idx),
        .wdata   (nv_key_data),
        .raddr   (key_idx_ff),
        .rdata   (key_rdata)
    );

    function automatic logic hit(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        return a >= lo && a <= hi;
    endfunction : hit
    // Mode sequencing
    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            dms_pkg::MODE_RUN: begin
                if (bg_req) begin
                    nxt_mode = dms_pkg::MODE_BGND;
                end else if (wait_instr) begin
                    nxt_mode = dms_pkg::MODE_WAIT;
                end
            end
            dms_pkg::MODE_WAIT: begin
                if (bg_req) begin
                    nxt_mode = dms_pkg::MODE_BGND;
                end else if (irq_req) begin
                    nxt_mode = dms_pkg::MODE_RUN;
                end
            end
            dms_pkg::MODE_BGND: begin
                if (dbg.exec && dbg.cls == dms_pkg::CMD_GO) begin
                    nxt_mode = dms_pkg::MODE_RUN;
                end
            end
            default: begin
                nxt_mode = dms_pkg::MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_ff <= dms_pkg::MODE_RUN;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // One-cycle CPU events
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ccr_i_clr_ff <= 1'b0;
            stack_ff     <= 1'b0;
            trace_ff     <= 1'b0;
        end else begin
            ccr_i_clr_ff <= mode_ff == dms_pkg::MODE_RUN && nxt_mode == dms_pkg::MODE_WAIT;
            stack_ff     <= mode_ff == dms_pkg::MODE_WAIT && nxt_mode == dms_pkg::MODE_RUN;
            trace_ff     <= dbg.exec && dbg.cls == dms_pkg::CMD_TRACE;
        end
    end

    assign cpu_run     = mode_ff == dms_pkg::MODE_RUN;
    assign cpu_clk_en  = mode_ff != dms_pkg::MODE_WAIT;
    assign ccr_i_clr   = ccr_i_clr_ff;
    assign stack_start = stack_ff;
    assign trace_step  = trace_ff;
    assign force_rst   = force_ff;

    // Option, protection and reset cause captured while reset is held
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            working_option_register_ff <= nv_opt_in;
            prot_ff <= nv_prot_in;
            srs_ff  <= rst_cause;
        end
    end

    assign redirect_off = working_option_register_ff[dms_pkg::KEY_ENABLE_BIT_BIT - 1];

    // Writable registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            opt1_ff <= dms_pkg::OPT_ONE_RST;
            opt2_ff <= dms_pkg::OPT_TWO_RST;
            wake_ff <= dms_pkg::PMC_RST;
            pmc1_ff <= dms_pkg::PMC_RST;
            pmc2_ff <= dms_pkg::PMC_RST;
            pmc3_ff <= dms_pkg::PMC_RST;
            cmpa_ff <= 16'h0000;
            cmpb_ff <= 16'h0000;
        end else if (reg_wr) begin
            unique case (reg_addr)
                dms_pkg::OFS_OPT_ONE:   opt1_ff <= reg_wdata;
                dms_pkg::OFS_OPT_TWO:   opt2_ff <= reg_wdata;
                dms_pkg::OFS_WAKEUP:    wake_ff <= reg_wdata;
                dms_pkg::OFS_PMC_ONE:   pmc1_ff <= reg_wdata;
                dms_pkg::OFS_PMC_TWO:   pmc2_ff <= reg_wdata;
                dms_pkg::OFS_PMC_THREE: pmc3_ff <= reg_wdata;
                dms_pkg::OFS_CMPA_HIGH: cmpa_ff[15:8] <= reg_wdata;
                dms_pkg::OFS_CMPA_LOW:  cmpa_ff[7:0] <= reg_wdata;
                dms_pkg::OFS_CMPB_HIGH: cmpb_ff[15:8] <= reg_wdata;
                dms_pkg::OFS_CMPB_LOW:  cmpb_ff[7:0] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Forced reset only through the debug port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            force_ff <= 1'b0;
        end else begin
            force_ff <= reg_wr && reg_from_dbg && reg_addr == dms_pkg::OFS_FORCE_RST
                        && reg_wdata[dms_pkg::FORCE_RST_BIT];
        end
    end

    // Key entry: each byte is compared a cycle after its write
    assign key_wr  = reg_wr && reg_addr == dms_pkg::OFS_KEY_ENTRY && reg_src_secure && !reg_from_dbg
                     && working_option_register_ff[dms_pkg::KEY_ENABLE_BIT_BIT] && secure;
    assign key_bad = key_miss_ff || key_rdata != key_byte_ff;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_idx_ff  <= 3'h0;
            key_pend_ff <= 1'b0;
            key_last_ff <= 1'b0;
            key_miss_ff <= 1'b0;
            key_byte_ff <= 8'h00;
        end else begin
            key_pend_ff <= key_wr;
            if (key_wr) begin
                key_idx_ff  <= key_idx_ff + 3'h1;
                key_last_ff <= key_idx_ff == 3'(dms_pkg::KEY_BYTES - 1);
                key_byte_ff <= reg_wdata;
            end
            if (key_pend_ff) begin
                key_miss_ff <= key_last_ff ? 1'b0 : key_bad;
            end
        end
    end

    // Unsecure sticky flags; only reset re-arms security
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_unsec_ff   <= 1'b0;
            erase_seen_ff  <= 1'b0;
            erase_unsec_ff <= 1'b0;
        end else begin
            if (key_pend_ff && key_last_ff && !key_bad) begin
                key_unsec_ff <= 1'b1;
            end
            if (mass_erase_done) begin
                erase_seen_ff <= 1'b1;
            end
            if (erase_seen_ff && blank_ok) begin
                erase_unsec_ff <= 1'b1;
            end
        end
    end

    assign secure    = working_option_register_ff[1:0] != dms_pkg::SEC_UNSECURED
                       && !key_unsec_ff && !erase_unsec_ff;
    assign mem_allow = !(secure && mem_tgt_secure && (!mem_src_secure || mem_src_dbg));

    // Read decode
    always_comb begin
        nxt_rdata = 8'h00;
        if (hit(reg_addr, dms_pkg::HP_LO, dms_pkg::HP_HI)) begin
            unique case (reg_addr)
                dms_pkg::OFS_RST_SRC:    nxt_rdata = srs_ff;
                dms_pkg::OFS_OPT_ONE:    nxt_rdata = opt1_ff;
                dms_pkg::OFS_OPT_TWO:    nxt_rdata = opt2_ff;
                dms_pkg::OFS_ID_HIGH:    nxt_rdata = ID_HIGH;
                dms_pkg::OFS_ID_LOW:     nxt_rdata = ID_LOW;
                dms_pkg::OFS_WAKEUP:     nxt_rdata = wake_ff;
                dms_pkg::OFS_PMC_ONE:    nxt_rdata = pmc1_ff;
                dms_pkg::OFS_PMC_TWO:    nxt_rdata = pmc2_ff;
                dms_pkg::OFS_PMC_THREE:  nxt_rdata = pmc3_ff;
                dms_pkg::OFS_CMPA_HIGH:  nxt_rdata = cmpa_ff[15:8];
                dms_pkg::OFS_CMPA_LOW:   nxt_rdata = cmpa_ff[7:0];
                dms_pkg::OFS_CMPB_HIGH:  nxt_rdata = cmpb_ff[15:8];
                dms_pkg::OFS_CMPB_LOW:   nxt_rdata = cmpb_ff[7:0];
                dms_pkg::OFS_TRACE_HIGH: nxt_rdata = trace_word[15:8];
                dms_pkg::OFS_TRACE_LOW:  nxt_rdata = trace_word[7:0];
                dms_pkg::OFS_WORK_OPT:   nxt_rdata = working_option_register_ff;
                dms_pkg::OFS_SEC_STAT:   nxt_rdata = {5'h00, erase_unsec_ff, key_unsec_ff, secure};
                default:                 nxt_rdata = 8'h00;
            endcase
        end else begin
            // Key bytes never read back
            unique case (reg_addr)
                dms_pkg::OFS_FINE_TRIM: nxt_rdata = nv_fine_trim;
                dms_pkg::OFS_OSC_TRIM:  nxt_rdata = nv_osc_trim;
                dms_pkg::OFS_PROT:      nxt_rdata = prot_ff;
                dms_pkg::OFS_NV_OPT:    nxt_rdata = working_option_register_ff;
                default:                nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
        end
    end
    assign reg_rdata = rdata_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_bgnd_suspends: assert property (mode_ff == dms_pkg::MODE_BGND |-> !cpu_run && cpu_clk_en)
        else $error("cpu runs in background mode");
    a_wait_clear_i: assert property (cpu_run && wait_instr && !bg_req
        |=> mode_ff == dms_pkg::MODE_WAIT && !cpu_clk_en && ccr_i_clr)
        else $error("wait entry did not clear mask");
    a_irq_wakes: assert property (mode_ff == dms_pkg::MODE_WAIT && irq_req && !bg_req
        |=> cpu_run && stack_start)
        else $error("interrupt did not leave wait");
    a_bg_wakes: assert property (mode_ff == dms_pkg::MODE_WAIT && bg_req
        |=> mode_ff == dms_pkg::MODE_BGND)
        else $error("background request did not wake");
    a_active_only: assert property (dbg.exec && dbg.cls inside {dms_pkg::CMD_CPU_REG, dms_pkg::CMD_TRACE,
        dms_pkg::CMD_GO} |-> mode_ff == dms_pkg::MODE_BGND)
        else $error("active command outside background");
    a_sec_bits: assert property (!key_unsec_ff && !erase_unsec_ff
        |-> secure == (working_option_register_ff[1:0] != dms_pkg::SEC_UNSECURED))
        else $error("security state wrong");
    a_opt_copy: assert property (disable iff (1'b0) $fell(rst) |-> working_option_register_ff == $past(nv_opt_in))
        else $error("option byte not copied");
    a_sec_block: assert property (secure && mem_req && mem_tgt_secure && mem_src_dbg |-> !mem_allow)
        else $error("debug reached secure memory");
    a_key_match: assert property (key_pend_ff && key_last_ff && key_bad |=> $stable(key_unsec_ff))
        else $error("bad key unsecured");
    a_key_dbg_refused: assert property (reg_wr && reg_from_dbg |=> !key_pend_ff)
        else $error("key accepted from debug");

    c_wait_irq: cover property (mode_ff == dms_pkg::MODE_WAIT && irq_req ##1 cpu_run);
    c_wait_bg: cover property (mode_ff == dms_pkg::MODE_WAIT ##1 mode_ff == dms_pkg::MODE_BGND);
    c_key_unlock: cover property ($rose(key_unsec_ff));
    c_erase_unlock: cover property ($rose(erase_unsec_ff));
endmodule : dms_sysregs
`default_nettype wire

// file: verification/dms_dbg_host.sv
// Background debug host model sending one command class at a time
`timescale 1ns/1ns
`default_nettype none
module dms_dbg_host (
    // Clock
    input  wire logic clk_sys,
    // Command lines
    output logic       dbg_valid,
    output logic [2:0] dbg_cls
);
    initial begin
        dbg_valid = 1'b0;
        dbg_cls = 3'h7;
    end
    // Class lines turn over once idle so a stale class is never seen
    task automatic issue(input logic [2:0] c);
        @(posedge clk_sys);
        dbg_valid <= 1'b1;
        dbg_cls <= c;
        @(posedge clk_sys);
        dbg_valid <= 1'b0;
        dbg_cls <= ~c;
    endtask : issue
endmodule : dms_dbg_host
`default_nettype wire

// file: verification/dms_bench.sv
// Self-checking bench for the debug-mode and security register block
`timescale 1ns/1ns
`default_nettype none
module debug_mode_security_sysregs_bench;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, reg_src_secure = 0, reg_from_dbg = 0;
    logic nv_key_we = 0, mass_erase_done = 0, blank_ok = 0, wait_instr = 0, irq_req = 0;
    logic mem_req = 0, mem_src_dbg = 0, mem_src_secure = 0, dbg_valid, dbg_exec, dbg_reject, dbg_lp_err;
    logic cpu_run, cpu_clk_en, ccr_i_clr, stack_start, secure, mem_allow, trace_step, force_rst, redirect_off;
    logic mem_tgt_secure = 1;
    logic [15:0] reg_addr = 0, trace_word;
    logic [7:0] reg_wdata = 0, reg_rdata, nv_opt_in, nv_fine_trim, nv_key_data = 0, ev = 0, v, key [8], rq [$], dq [$];
    logic [2:0] nv_key_idx = 0, dbg_cls;
    integer seed = 30, mismatches = 0, checks = 0, cyc = 0;
    always #4 clk_sys = ~clk_sys;
    dms_sysregs DUT (.*, .nv_prot_in(8'h00), .nv_osc_trim(8'h00), .rst_cause(8'h00));
    dms_dbg_host HOST (.clk_sys(clk_sys), .dbg_valid(dbg_valid), .dbg_cls(dbg_cls));
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic rs(input logic [7:0] o);
        @(posedge clk_sys) nv_opt_in <= o;
        rst <= 1;
        repeat (5) @(posedge clk_sys);
        rst <= 0;
    endtask : rs
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        rq.push_back(e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk_sys) reg_rd <= 0;
    endtask : rd
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk_sys) reg_wr <= 0;
    endtask : wr
    task automatic dbg(input int c, input logic [7:0] e);
        dq.push_back(e);
        HOST.issue(c[2:0]);
    endtask : dbg
    task automatic kent(input logic [7:0] x);
        for (int i = 0; i < 8; i++) wr(16'h1818, key[i] ^ x);
        repeat (2) @(negedge clk_sys);
    endtask : kent
    task automatic go_wait;
        @(posedge clk_sys) wait_instr <= 1;
        @(posedge clk_sys) wait_instr <= 0;
        @(negedge clk_sys) cmp(cpu_clk_en, 0);
        cmp(ccr_i_clr, 1);
    endtask : go_wait
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // Results are matched oldest first
    always @(posedge clk_sys) begin
        if (rd_d) cmp(reg_rdata, rq.pop_front());
        rd_d <= reg_rd;
        // Pulse tally: trace steps low nibble, forced resets high nibble
        if (!rst) ev <= ev + {3'h0, force_rst, 3'h0, trace_step};
        if (dbg_valid) cmp({5'h0, dbg_exec, dbg_reject, dbg_lp_err}, dq.pop_front());
        if (++cyc == 3000) begin
            mismatches++;
            test_done;
        end
    end
    initial begin
        trace_word = 16'($random(seed));
        nv_fine_trim = 8'($random(seed));
        v = 8'($random(seed));
        rs(8'h80);
        @(negedge clk_sys) cmp(secure, 1);
        rd(16'h1816, 8'h80);
        wr(16'h1816, 8'hff);
        rd(16'h1816, 8'h80);
        rd(16'hffb0, 8'h00);
        rd(16'h1804, 8'h00);
        wr(16'h1802, v);
        rd(16'h1802, v);
        wr(16'h1801, 8'h01);
        rd(16'h1814, trace_word[15:8]);
        rd(16'hffae, nv_fine_trim);
        for (int c = 0; c < 8; c++) if (c != 3) dbg(c, c < 4 ? 8'h04 : 8'h02);
        dbg(3, 8'h04);
        dbg(6, 8'h04);
        go_wait();
        for (int c = 0; c < 8; c++) if (c != 3) dbg(c, c == 1 ? 8'h01 : 8'h02);
        dbg(3, 8'h04);
        @(negedge clk_sys) cmp(cpu_run, 0);
        for (int c = 0; c < 8; c++) if (c != 6) dbg(c, c == 7 ? 8'h02 : 8'h04);
        dbg(6, 8'h04);
        @(negedge clk_sys) cmp(cpu_run, 1);
        go_wait();
        @(posedge clk_sys) irq_req <= 1;
        @(posedge clk_sys) irq_req <= 0;
        @(negedge clk_sys) cmp(cpu_run, 1);
        cmp(stack_start, 1);
        @(posedge clk_sys) mem_req <= 1;
        mem_src_dbg <= 1;
        mem_src_secure <= 1;
        @(negedge clk_sys) cmp(mem_allow, 0);
        @(posedge clk_sys) mem_tgt_secure <= 0;
        @(negedge clk_sys) cmp(mem_allow, 1);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            key[i] = 8'($random(seed));
            nv_key_we <= 1;
            nv_key_idx <= i[2:0];
            nv_key_data <= key[i];
        end
        @(posedge clk_sys) nv_key_we <= 0;
        reg_src_secure <= 1;
        kent(8'h01);
        cmp(secure, 1);
        @(posedge clk_sys) reg_from_dbg <= 1;
        kent(8'h00);
        cmp(secure, 1);
        wr(16'h1801, 8'h01);
        @(posedge clk_sys) reg_from_dbg <= 0;
        kent(8'h00);
        cmp(secure, 0);
        rs(8'h03);
        kent(8'h00);
        cmp(secure, 1);
        @(posedge clk_sys) mass_erase_done <= 1;
        @(posedge clk_sys) mass_erase_done <= 0;
        blank_ok <= 1;
        @(posedge clk_sys) blank_ok <= 0;
        repeat (2) @(negedge clk_sys);
        cmp(secure, 0);
        rs(8'h42);
        @(negedge clk_sys) cmp(secure, 0);
        cmp(redirect_off, 1);
        cmp(ev, 8'h11);
        test_done;
    end
endmodule : debug_mode_security_sysregs_bench
`default_nettype wire
